//--- gpio_map.vh
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// ****************************************************************
// port register groups
// ****************************************************************
`define PORT0_BASE 16'hFCA0
`define PORT1_BASE 16'hFCC0
`define PORT2_BASE 16'hFCE0
`define PORT0_WIDTH 16
`define PORT1_WIDTH 16
`define PORT2_WIDTH 14

// ****************************************************************
// register index inside a group
// ****************************************************************
`define IDX_PIN_DIRECTION 4'h0
`define IDX_OUTPUT_LEVEL 4'h1
`define IDX_PIN_LEVEL 4'h2
`define IDX_FALL_IRQ_ENABLE 4'h3
`define IDX_RISE_IRQ_ENABLE 4'h4
`define IDX_IRQ_PENDING 4'h5
`define IDX_OUTPUT_SET 4'h6
`define IDX_OUTPUT_CLEAR 4'h7
`define IDX_BIT_MAP_CONFIG 4'h8
`define IDX_SINGLE_BIT_ACCESS_A 4'h9
`define IDX_SINGLE_BIT_ACCESS_B 4'hA
`define IDX_PIN_FUNCTION_SELECT 4'hB

// ****************************************************************
// summary interrupt registers
// ****************************************************************
`define SUMMARY_STATUS_ADDR 16'hFCF0
`define SUMMARY_MASK_ADDR 16'hFCF1

// ****************************************************************
// bit_map_config fields (lsb positions, each 4 bits wide)
// ****************************************************************
`define ENGINE_B_DATA_SELECT_LSB 12
`define ENGINE_B_PIN_SELECT_LSB 8
`define ENGINE_A_DATA_SELECT_LSB 4
`define ENGINE_A_PIN_SELECT_LSB 0

// ****************************************************************
// reset values
// ****************************************************************
`define REG_RESET 16'h0000
`define SUMMARY_RESET 3'h0

`endif

//--- interruptible_gpio_ports.v
`timescale 1ns/10ps
`include "gpio_map.vh"

// How it works
// [R1] pin is gpio only while function select clear
// [R2] three ports: sixteen, sixteen, fourteen pins
// [R3] groups at 0xFCA0, 0xFCC0, 0xFCE0, consecutive offsets
// [R4] direction one means output, resets zero, readable
// [R5] output level drives only output pins
// [R6] pin level shows every pin, peripheral too
// [R7] enabled falling edge sets pending bit
// [R8] enabled rising edge sets pending bit
// [R9] port interrupt request high while any pending bit
// [R10] writing one clears pending bit, zero keeps
// [R11] set register forces selected output bits high
// [R12] clear register forces selected output bits low
// [R13] bit map config holds four nibble fields
// [R14] engine write copies data bit to pin
// [R15] engine read returns pin at data bit
// [R16] two flop sync, edge against previous level
module interruptible_gpio_ports #(
	parameter PORT0_WIDTH = `PORT0_WIDTH,
	parameter PORT1_WIDTH = `PORT1_WIDTH,
	parameter PORT2_WIDTH = `PORT2_WIDTH
) (
	input wire clock_i,
	input wire rst_b_i,
	input wire [15:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [15:0] rdata_o,
	input wire [47:0] pin_in_i,
	output wire [47:0] pin_out_o,
	output wire [47:0] pin_oe_o,
	output wire [47:0] pin_function_select_o,
	input wire [47:0] periph_out_i,
	input wire [47:0] periph_oe_i,
	output wire [2:0] port_irq_o,
	output wire irq_o
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function [15:0] width_mask;
		input integer w;
		integer k;
		begin
			width_mask = 16'h0000;
			for (k = 0; k < 16; k = k + 1) begin
				if (k < w) begin
					width_mask[k] = 1'b1;
				end
			end
		end
	endfunction

	function [15:0] base_of;
		input integer p;
		begin
			if (p == 0) begin
				base_of = `PORT0_BASE;
			end else if (p == 1) begin
				base_of = `PORT1_BASE;
			end else begin
				base_of = `PORT2_BASE;
			end
		end
	endfunction

	wire [47:0] port_rd;
	wire [2:0] port_hit;
	wire [2:0] port_event;
	reg [15:0] rdata_r;
	reg [15:0] rdata_nxt;
	reg [2:0] sum_stat_r;
	reg [2:0] sum_stat_nxt;
	reg [2:0] sum_mask_r;
	reg irq_r;

	// ****************************************************************
	// one register group per port
	// ****************************************************************
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : port
			localparam integer PW = (p == 0) ? PORT0_WIDTH :
				(p == 1) ? PORT1_WIDTH : PORT2_WIDTH; // [R2]
			localparam [15:0] PMASK = width_mask(PW);
			localparam [15:0] BASE = base_of(p);

			reg [15:0] pin_direction_r;
			reg [15:0] output_level_r;
			reg [15:0] output_level_nxt;
			reg [15:0] fall_irq_enable_r;
			reg [15:0] rise_irq_enable_r;
			reg [15:0] irq_pending_r;
			reg [15:0] irq_pending_nxt;
			reg [15:0] bit_map_config_r;
			reg [15:0] pin_function_select_r;
			reg [15:0] sync1_r;
			reg [15:0] sync2_r;
			reg [15:0] prev_r;
			reg [15:0] pin_out_r;
			reg [15:0] pin_oe_r;
			reg port_irq_r;
			reg [15:0] rd_word;
			reg [15:0] clr_bits;

			// upper address bits pick the group, low nibble the register
			wire hit = (addr_i[15:4] == BASE[15:4]); // [R3]
			wire [3:0] idx = addr_i[3:0];
			wire wr = wr_i & hit;
			wire [15:0] wd = wdata_i & PMASK;
			wire [3:0] a_pin =
				bit_map_config_r[`ENGINE_A_PIN_SELECT_LSB +: 4]; // [R13]
			wire [3:0] a_dat =
				bit_map_config_r[`ENGINE_A_DATA_SELECT_LSB +: 4];
			wire [3:0] b_pin =
				bit_map_config_r[`ENGINE_B_PIN_SELECT_LSB +: 4];
			wire [3:0] b_dat =
				bit_map_config_r[`ENGINE_B_DATA_SELECT_LSB +: 4];
			// edges seen on output pins too, since the pad is sampled
			wire [15:0] rise = sync2_r & ~prev_r; // [R16]
			wire [15:0] fall = ~sync2_r & prev_r;
			wire [15:0] ev = (rise & rise_irq_enable_r) |
				(fall & fall_irq_enable_r); // [R7] [R8]

			always @* begin
				output_level_nxt = output_level_r;
				if (wr) begin
					case (idx)
					`IDX_OUTPUT_LEVEL: begin
						output_level_nxt = wd;
					end
					`IDX_OUTPUT_SET: begin
						output_level_nxt = output_level_r | wd; // [R11]
					end
					`IDX_OUTPUT_CLEAR: begin
						output_level_nxt = output_level_r & ~wd; // [R12]
					end
					`IDX_SINGLE_BIT_ACCESS_A: begin
						output_level_nxt[a_pin] = wdata_i[a_dat]; // [R14]
					end
					`IDX_SINGLE_BIT_ACCESS_B: begin
						output_level_nxt[b_pin] = wdata_i[b_dat]; // [R14]
					end
					default: begin
						output_level_nxt = output_level_r;
					end
					endcase
				end
				// pins 14 and 15 of a narrow port never exist
				output_level_nxt = output_level_nxt & PMASK;
			end

			always @* begin
				clr_bits = 16'h0000;
				if (wr && idx == `IDX_IRQ_PENDING) begin
					clr_bits = wd; // [R10]
				end
				// a new edge wins over a clear in the same cycle
				irq_pending_nxt = (irq_pending_r & ~clr_bits) | ev;
			end

			always @* begin
				rd_word = 16'h0000;
				case (idx)
				`IDX_PIN_DIRECTION: begin
					rd_word = pin_direction_r; // [R4]
				end
				`IDX_OUTPUT_LEVEL: begin
					rd_word = output_level_r;
				end
				`IDX_PIN_LEVEL: begin
					rd_word = sync2_r; // [R6]
				end
				`IDX_FALL_IRQ_ENABLE: begin
					rd_word = fall_irq_enable_r;
				end
				`IDX_RISE_IRQ_ENABLE: begin
					rd_word = rise_irq_enable_r;
				end
				`IDX_IRQ_PENDING: begin
					rd_word = irq_pending_r;
				end
				`IDX_BIT_MAP_CONFIG: begin
					rd_word = bit_map_config_r;
				end
				`IDX_SINGLE_BIT_ACCESS_A: begin
					rd_word[a_dat] = sync2_r[a_pin]; // [R15]
				end
				`IDX_SINGLE_BIT_ACCESS_B: begin
					rd_word[b_dat] = sync2_r[b_pin]; // [R15]
				end
				`IDX_PIN_FUNCTION_SELECT: begin
					rd_word = pin_function_select_r;
				end
				default: begin
					rd_word = 16'h0000;
				end
				endcase
			end

			always @(posedge clock_i) begin
				if (!rst_b_i) begin
					pin_direction_r <= `REG_RESET; // [R4]
					output_level_r <= `REG_RESET;
					fall_irq_enable_r <= `REG_RESET;
					rise_irq_enable_r <= `REG_RESET;
					irq_pending_r <= `REG_RESET;
					bit_map_config_r <= `REG_RESET;
					pin_function_select_r <= `REG_RESET; // [R1]
					sync1_r <= `REG_RESET;
					sync2_r <= `REG_RESET;
					prev_r <= `REG_RESET;
					pin_out_r <= `REG_RESET;
					pin_oe_r <= `REG_RESET;
					port_irq_r <= 1'b0;
				end else begin
					sync1_r <= pin_in_i[16*p +: 16];
					sync2_r <= sync1_r & PMASK; // [R16]
					prev_r <= sync2_r;
					output_level_r <= output_level_nxt;
					irq_pending_r <= irq_pending_nxt;
					port_irq_r <= |irq_pending_nxt; // [R9]
					if (wr) begin
						case (idx)
						`IDX_PIN_DIRECTION: begin
							pin_direction_r <= wd; // [R4]
						end
						`IDX_FALL_IRQ_ENABLE: begin
							fall_irq_enable_r <= wd;
						end
						`IDX_RISE_IRQ_ENABLE: begin
							rise_irq_enable_r <= wd;
						end
						`IDX_BIT_MAP_CONFIG: begin
							bit_map_config_r <= wdata_i; // [R13]
						end
						`IDX_PIN_FUNCTION_SELECT: begin
							pin_function_select_r <= wd;
						end
						default: begin
							pin_direction_r <= pin_direction_r;
						end
						endcase
					end
					// selected peripheral takes the pad, else gpio
					pin_out_r <= ((pin_function_select_r &
						periph_out_i[16*p +: 16]) |
						(~pin_function_select_r & output_level_r)) &
						PMASK; // [R1] [R5]
					pin_oe_r <= ((pin_function_select_r &
						periph_oe_i[16*p +: 16]) |
						(~pin_function_select_r & pin_direction_r)) &
						PMASK; // [R5]
				end
			end

			assign port_rd[16*p +: 16] = hit ? rd_word : 16'h0000;
			assign port_hit[p] = hit;
			assign port_event[p] = |ev;
			assign pin_out_o[16*p +: 16] = pin_out_r;
			assign pin_oe_o[16*p +: 16] = pin_oe_r;
			assign pin_function_select_o[16*p +: 16] =
				pin_function_select_r;
			assign port_irq_o[p] = port_irq_r;
		end
	endgenerate

	// ****************************************************************
	// summary interrupt and read port
	// ****************************************************************
	always @* begin
		sum_stat_nxt = sum_stat_r;
		if (wr_i && addr_i == `SUMMARY_STATUS_ADDR) begin
			sum_stat_nxt = sum_stat_r & ~wdata_i[2:0];
		end
		// set after clear so a same-cycle event survives
		sum_stat_nxt = sum_stat_nxt | port_event;
	end

	always @* begin
		rdata_nxt = 16'h0000;
		if (rd_i) begin
			if (|port_hit) begin
				rdata_nxt = port_rd[15:0] | port_rd[31:16] |
					port_rd[47:32];
			end else if (addr_i == `SUMMARY_STATUS_ADDR) begin
				rdata_nxt = {13'h0000, sum_stat_r};
			end else if (addr_i == `SUMMARY_MASK_ADDR) begin
				rdata_nxt = {13'h0000, sum_mask_r};
			end else begin
				rdata_nxt = 16'h0000;
			end
		end
	end

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			rdata_r <= 16'h0000;
			sum_stat_r <= `SUMMARY_RESET;
			sum_mask_r <= `SUMMARY_RESET;
			irq_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			sum_stat_r <= sum_stat_nxt;
			if (wr_i && addr_i == `SUMMARY_MASK_ADDR) begin
				sum_mask_r <= wdata_i[2:0];
			end
			irq_r <= |(sum_stat_nxt & sum_mask_r);
		end
	end

	assign rdata_o = rdata_r;
	assign irq_o = irq_r;

endmodule // interruptible_gpio_ports

//--- gpio_pins.sv
`timescale 1ns/10ps
// ****
// board side of the pads
// ****
module gpio_pins (
	input wire logic [47:0] out_i,
	input wire logic [47:0] oe_i,
	input wire logic [47:0] board_i,
	output logic [47:0] pad_o
);
	// the board keeps driving undriven lines, so no stale level
	assign pad_o = (out_i & oe_i) | (board_i & ~oe_i);
endmodule // gpio_pins

//--- gpio_chk.sv
`timescale 1ns/10ps
module gpio_chk (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic [47:0] pin_in_i,
	input wire logic [47:0] pin_out_o,
	input wire logic [47:0] pin_oe_o,
	input wire logic [47:0] pin_function_select_o,
	input wire logic [47:0] periph_out_i,
	input wire logic [47:0] periph_oe_i,
	input wire logic [2:0] port_irq_o,
	input wire logic irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	logic [5:0] chg_r;
	wire gp0 = pin_function_select_o[15:0] == 16'h0000;
	// port 1 pad changes, window covers the sync delay
	always @(posedge clock_i)
		chg_r <= {chg_r[4:0], pin_in_i[31:16] != $past(pin_in_i[31:16])};
	sequence s_wr(a);
		wr_i && addr_i == a && gp0;
	endsequence
	a_dir_to_oe: assert property (s_wr(16'hFCA0) |-> ##2
		pin_oe_o[15:0] == $past(wdata_i, 2)) else $error("oe");
	a_set_high: assert property (s_wr(16'hFCA6) |-> ##2
		(pin_out_o[15:0] & $past(wdata_i, 2)) == $past(wdata_i, 2))
		else $error("set");
	a_clr_low: assert property (s_wr(16'hFCA7) |-> ##2
		(pin_out_o[15:0] & $past(wdata_i, 2)) == 16'h0000) else $error("clr");
	a_sel_write: assert property (wr_i && addr_i == 16'hFCAB |=>
		pin_function_select_o[15:0] == $past(wdata_i)) else $error("sel");
	a_port2_top: assert property (pin_out_o[47:46] == 2'b00 &&
		pin_oe_o[47:46] == 2'b00) else $error("p2");
	a_pend_clear: assert property ($fell(port_irq_o[1]) |->
		$past(wr_i && addr_i == 16'hFCC5)) else $error("irq fall");
	a_irq_cause: assert property ($rose(port_irq_o[1]) |->
		|chg_r) else $error("irq rise");
	a_sum_fall: assert property ($fell(irq_o) |->
		$past(wr_i && addr_i[15:1] == 15'h7E78)) else $error("sum");
endmodule // gpio_chk
bind interruptible_gpio_ports gpio_chk u_chk (.clock_i, .rst_b_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .pin_in_i, .pin_out_o, .pin_oe_o,
	.pin_function_select_o, .periph_out_i, .periph_oe_i, .port_irq_o,
	.irq_o);

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
	logic clock_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
	logic [15:0] addr_i = 0, wdata_i = 0, v, s, c, exp_q[$];
	logic [47:0] board = 0, periph_out_i = 0, periph_oe_i = 0;
	wire [47:0] pin_in_i, pin_out_o, pin_oe_o;
	wire [15:0] rdata_o;
	wire [2:0] port_irq_o;
	wire irq_o;
	int n_mismatch = 0, compares = 0;
	always #4 clock_i = ~clock_i;
	interruptible_gpio_ports u_dut (.clock_i, .rst_b_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .pin_in_i, .pin_out_o, .pin_oe_o,
		.pin_function_select_o(), .periph_out_i, .periph_oe_i,
		.port_irq_o, .irq_o);
	gpio_pins u_pins (.out_i(pin_out_o), .oe_i(pin_oe_o), .board_i(board),
		.pad_o(pin_in_i));
	task cmp(input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask
	// ****
	// read data stands only in the cycle after the strobe
	// ****
	always @(posedge clock_i) begin
		rd_d <= rd_i;
		if (rd_d)
			cmp(exp_q.pop_front(), rdata_o);
	end
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hD97EC44E));
		repeat (4) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int p = 0; p < 3; p++)
			for (int i = 0; i < 13; i++)
				rd(16'hFCA0 + 16'(p * 32 + i), 16'h0000);
		$display("reset test done");
		for (int p = 0; p < 3; p++)
			for (int i = 0; i < 5; i++) begin
				v = $urandom;
				if (i != 2)
					wr(16'hFCA0 + 16'(p * 32 + i), v);
				if (i != 2)
					rd(16'hFCA0 + 16'(p * 32 + i), p == 2 ? v & 16'h3FFF : v);
			end
		for (int p = 0; p < 3; p++) begin
			wr(16'hFCA3 + 16'(p * 32), 16'h0000);
			wr(16'hFCA4 + 16'(p * 32), 16'h0000);
			wr(16'hFCA0 + 16'(p * 32), 16'h0000);
			wr(16'hFCA5 + 16'(p * 32), 16'hFFFF);
		end
		wr(16'hFCF0, 16'h0007);
		$display("readback test done");
		v = $urandom;
		s = $urandom;
		c = $urandom;
		board[15:0] <= 16'($urandom);
		wr(16'hFCA0, 16'h00FF);
		wr(16'hFCA1, v);
		wr(16'hFCA6, s);
		wr(16'hFCA7, c);
		rd(16'hFCA1, (v | s) & ~c);
		repeat (4) @(posedge clock_i);
		rd(16'hFCA2, ((v | s) & ~c & 16'h00FF) | (board[15:0] & 16'hFF00));
		periph_out_i <= {16'($urandom), 32'($urandom)};
		periph_oe_i <= {16'($urandom), 32'($urandom)};
		wr(16'hFCAB, 16'hFFFF);
		repeat (4) @(posedge clock_i);
		v = (periph_out_i[15:0] & periph_oe_i[15:0]);
		rd(16'hFCA2, v | (board[15:0] & ~periph_oe_i[15:0]));
		wr(16'hFCAB, 16'h0000);
		$display("pin test done");
		wr(16'hFCA0, 16'hFFFF);
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			s = $urandom;
			c = 16'h0000;
			c[v[3:0]] = s[v[7:4]];
			c[v[11:8]] = ~s[v[15:12]];
			wr(16'hFCA8, v);
			wr(16'hFCA1, 16'h0000);
			wr(16'hFCA9, s);
			wr(16'hFCAA, ~s);
			rd(16'hFCA8, v);
			rd(16'hFCA1, c);
			repeat (4) @(posedge clock_i);
			rd(16'hFCA9, 16'(c[v[3:0]]) << v[7:4]);
			rd(16'hFCAA, 16'(c[v[11:8]]) << v[15:12]);
		end
		$display("bit engine test done");
		wr(16'hFCF1, 16'h0007);
		wr(16'hFCC4, 16'h0008);
		wr(16'hFCC3, 16'h0010);
		board[20:19] <= 2'b11;
		repeat (6) @(posedge clock_i);
		cmp(16'h0001, {15'h0000, irq_o});
		rd(16'hFCC5, 16'h0008);
		wr(16'hFCC5, 16'h0010);
		rd(16'hFCC5, 16'h0008);
		board[20] <= 1'b0;
		repeat (6) @(posedge clock_i);
		rd(16'hFCC5, 16'h0018);
		wr(16'hFCC5, 16'h0008);
		rd(16'hFCC5, 16'h0010);
		cmp(16'h0001, {15'h0000, port_irq_o[1]});
		wr(16'hFCC5, 16'h0010);
		wr(16'hFCF0, 16'h0007);
		@(posedge clock_i);
		cmp(16'h0000, {13'h0000, port_irq_o});
		cmp(16'h0000, {15'h0000, irq_o});
		$display("interrupt test done");
		for (int i = 0; i < 8 && exp_q.size() > 0; i++)
			@(posedge clock_i);
		if (exp_q.size() > 0)
			n_mismatch++;
		end_sim;
	end
endmodule // testbench
